// >>> tb/test_tx_fifo_set_flags.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
// =====
// bench top
module test_tx_fifo_set_flags
    import txf_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, ack, rd, sof, irq;
    logic [3:0] ep;
    logic [32:0] expq[$];
    logic [32:0] exp_v;
    int error_cnt = 0, n_compared = 0;
    initial forever #5 pclk = ~pclk;
    txf_usb_host HOST (.pclk(pclk), .usb_tx_ack(ack), .usb_tx_ep(ep), .usb_tx_read(rd),
        .usb_sof(sof));
    txf_flags DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .usb_tx_ack(ack), .usb_tx_ep(ep), .usb_tx_read(rd),
        .usb_sof(sof), .irq(irq));
    task complete_run();
        if (expq.size() != 0) error_cnt++;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // apb transfer, waits for pready under a bound
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (!pready && n < 50);
        if (!pready) begin error_cnt++; complete_run(); end
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task rdx(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(0, a, 0);
    endtask
    // read result monitor
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (expq.size() == 0) begin
                error_cnt++;
                $display("ERROR %0t: extra read", $time);
            end else begin
                exp_v = expq.pop_front();
                `CHK({pslverr, prdata}, exp_v)
            end
        end
    end
    initial begin #1ms; error_cnt++; complete_run(); end
    initial begin
        void'($urandom(32'h34b0_283c));
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_0008});
        rdx(8'h20, {1'b1, 32'h0});
        apb(1, 8'h24, $urandom);
        apb(1, TXF_OFS_IRQ_MASK, 32'h0000_0003);
        apb(1, TXF_OFS_COUNT, $urandom & 32'h0000_03ff);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_0040});
        apb(1, TXF_OFS_COUNT, $urandom & 32'h0000_03ff);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_00c4});
        apb(1, TXF_OFS_INDEX, 32'h0000_0001);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_0008});
        apb(1, TXF_OFS_INDEX, 32'h0000_0000);
        apb(1, TXF_OFS_COUNT, $urandom & 32'h0000_03ff);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_00c5});
        `CHK(irq, 1'b1)
        HOST.ev(1, 4'h0);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_00c5});
        HOST.sof();
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_0081});
        apb(1, TXF_OFS_FLAGS, 32'h0000_0031);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_0080});
        apb(1, TXF_OFS_IRQ_STAT, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1, TXF_OFS_CTL, 32'h0000_0000);
        apb(1, TXF_OFS_CTL, 32'h0000_0002);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_0008});
        HOST.ev(0, 4'h0);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_000a});
        `CHK(irq, 1'b1)
        // mid-run reset brings every endpoint back to its default flags
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        `CHK(irq, 1'b0)
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_0008});
        // advance request is ignored while automatic management is on
        apb(1, TXF_OFS_COUNT, $urandom & 32'h0000_03ff);
        apb(1, TXF_OFS_CTL, 32'h0000_0006);
        rdx(TXF_OFS_FLAGS, {1'b0, 32'h0000_0040});
        complete_run();
    end
endmodule

// >>> tb/txf_flags_sva.sv
`timescale 1ns/1ps
// =====
// checker on the flag block ports
module txf_flags_chk
    import txf_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        usb_tx_read,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phases
    logic acc, wr, mapped;
    assign acc    = psel && penable;
    assign wr     = acc && pwrite;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    sequence s_cnt_wr; wr && paddr == TXF_OFS_COUNT; endsequence
    sequence s_flag_rd; psel && !penable && !pwrite && paddr == TXF_OFS_FLAGS ##1 acc; endsequence
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_unused; s_flag_rd |-> prdata[5:4] == 2'b00 && prdata[31:8] == 0; endproperty
    a_unused: assert property (p_unused) else $error("unused flag bits set");
    property p_empty; s_flag_rd |-> prdata[3] == (prdata[7:6] == TXF_SETS_NONE); endproperty
    a_empty: assert property (p_empty) else $error("empty flag wrong");
    property p_full; s_flag_rd |-> prdata[2] == (prdata[7:6] == TXF_SETS_BOTH); endproperty
    a_full: assert property (p_full) else $error("full flag wrong");
    property p_err; acc && !mapped && !pwrite |-> pslverr && prdata == 0; endproperty
    a_err: assert property (p_err) else $error("unmapped read not refused");
    property p_err_wr; acc && !mapped && pwrite |-> pslverr; endproperty
    a_err_wr: assert property (p_err_wr) else $error("unmapped write not refused");
    property p_ok; acc && mapped |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_irq_rst; $rose(presetn) |-> !irq; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
    property p_irq_cause; $rose(irq) |-> $past(wr || usb_tx_read) || $past(wr || usb_tx_read, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
    property p_cnt; s_cnt_wr ##2 s_flag_rd |-> prdata[7:6] != TXF_SETS_NONE; endproperty
    a_cnt: assert property (p_cnt) else $error("count write added no set");
endmodule
bind txf_flags txf_flags_chk CHK (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_tx_read(usb_tx_read), .irq(irq));

// >>> tb/txf_usb_host.sv
`timescale 1ns/1ps
// =====
// usb side: one-cycle event pulses, endpoint scrambled when idle
module txf_usb_host (
    input wire logic  pclk,
    output logic       usb_tx_ack,
    output logic [3:0] usb_tx_ep,
    output logic       usb_tx_read,
    output logic       usb_sof
);
    initial begin
        usb_tx_ack = 0; usb_tx_ep = 4'hf; usb_tx_read = 0; usb_sof = 0;
    end
    // ack or empty read of endpoint e
    task ev(input logic a, input logic [3:0] e);
        usb_tx_ack <= a; usb_tx_read <= !a; usb_tx_ep <= e;
        @(posedge pclk);
        usb_tx_ack <= 0; usb_tx_read <= 0; usb_tx_ep <= ~e;
        @(posedge pclk);
    endtask
    // start of frame pulse
    task sof();
        usb_sof <= 1;
        @(posedge pclk);
        usb_sof <= 0;
        @(posedge pclk);
    endtask
endmodule

// >>> verilog/txf_flags.sv
`timescale 1ns/1ps
module txf_flags
    import txf_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        usb_tx_ack,    // successful in transfer, endpoint below
    input  wire logic [3:0]  usb_tx_ep,
    input  wire logic        usb_tx_read,   // sie reads a byte with no set present
    input  wire logic        usb_sof,       // start of frame pulse
    output logic             irq
);

    // =====================================================================
    // per endpoint state, then shared index, count, control and interrupt registers
    logic [1:0]            sets_reg     [TXF_NUM_EP];
    logic                  ovf_reg      [TXF_NUM_EP];
    logic                  urf_reg      [TXF_NUM_EP];
    logic [TXF_NUM_EP-1:0] pend_reg;      // acked transfers waiting for sof
    logic [TXF_EP_W-1:0]   index_reg;
    logic [TXF_CNT_W-1:0]  count_reg;
    logic                  atm_reg;
    logic [TXF_IRQ_W-1:0]  irq_stat_reg;
    logic [TXF_IRQ_W-1:0]  irq_mask_reg;

    // =====================================================================
    // bus decode
    logic       wr_en;
    logic       rd_en;
    logic       wr_count;
    logic       wr_advance;
    logic [1:0] sets_sel;
    logic [7:0] flags_view;

    assign wr_en      = psel && penable && pwrite;
    assign rd_en      = psel && !penable && !pwrite;                        // read setup cycle
    assign wr_count   = wr_en && paddr == TXF_OFS_COUNT;
    assign wr_advance = wr_en && paddr == TXF_OFS_CTL && !atm_reg
                        && pwdata[TXF_BIT_ADVANCE];
    // zero wait states: every access phase completes in its first cycle
    assign pready     = 1'b1;
    assign sets_sel   = sets_reg[index_reg];

    // flag byte for the selected endpoint, bits 5:4 held at zero
    always_comb begin
        flags_view                   = 8'h00;
        flags_view[TXF_BIT_SET1]     = sets_sel[1];
        flags_view[TXF_BIT_SET0]     = sets_sel[0];
        flags_view[TXF_BIT_EMPTY]    = sets_sel == TXF_SETS_NONE;
        flags_view[TXF_BIT_FULL]     = sets_sel == TXF_SETS_BOTH;
        flags_view[TXF_BIT_UNDERRUN] = urf_reg[index_reg];
        flags_view[TXF_BIT_OVERFLOW] = ovf_reg[index_reg];
    end

    // unmapped addresses answer with an error
    always_comb begin
        case (paddr)
            TXF_OFS_INDEX, TXF_OFS_FLAGS, TXF_OFS_COUNT,
            TXF_OFS_CTL, TXF_OFS_IRQ_STAT, TXF_OFS_IRQ_MASK: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    // read data register
    // loaded in the setup cycle so the word stands for the whole access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                TXF_OFS_INDEX:    prdata <= {28'h000_0000, index_reg};
                TXF_OFS_FLAGS:    prdata <= {24'h00_0000, flags_view};
                TXF_OFS_COUNT:    prdata <= {22'h00_0000, count_reg};
                TXF_OFS_CTL:      prdata <= {29'h0000_0000, atm_reg, 2'b00};
                TXF_OFS_IRQ_STAT: prdata <= {30'h0000_0000, irq_stat_reg};
                TXF_OFS_IRQ_MASK: prdata <= {30'h0000_0000, irq_mask_reg};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    // =====================================================================
    // software configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_reg    <= '0;
            count_reg    <= '0;
            atm_reg      <= TXF_CTL_RESET[TXF_BIT_ATM];
            irq_mask_reg <= '0;
        end else if (wr_en) begin
            case (paddr)
                TXF_OFS_INDEX:    index_reg    <= pwdata[TXF_EP_W-1:0];
                TXF_OFS_COUNT:    count_reg    <= pwdata[TXF_CNT_W-1:0];
                TXF_OFS_CTL:      atm_reg      <= pwdata[TXF_BIT_ATM];
                TXF_OFS_IRQ_MASK: irq_mask_reg <= pwdata[TXF_IRQ_W-1:0];
                default:          ;
            endcase
        end
    end

    // =====================================================================
    // presence flag machine, one per endpoint
    // a drop is applied before a count write of the same cycle, so a frame
    // drop and a write together leave the endpoint full without an overflow
    logic [TXF_NUM_EP-1:0] ovf_evt;
    logic [TXF_NUM_EP-1:0] urf_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= '0;
            for (int e = 0; e < TXF_NUM_EP; e++) begin
                sets_reg[e] <= TXF_FLAGS_RESET[TXF_BIT_SET1:TXF_BIT_SET0];
                ovf_reg[e]  <= TXF_FLAGS_RESET[TXF_BIT_OVERFLOW];
                urf_reg[e]  <= TXF_FLAGS_RESET[TXF_BIT_UNDERRUN];
            end
        end else begin
            for (int e = 0; e < TXF_NUM_EP; e++) begin
                logic [1:0] s;
                logic       sel;
                logic       drop;
                s    = sets_reg[e];
                sel  = index_reg == TXF_EP_W'(e);
                // acked transfer waits for the frame boundary
                // several acks in one frame still drop only one set there
                drop = (sel && wr_advance) ||
                       (atm_reg && usb_sof && pend_reg[e]);
                if (usb_sof) begin
                    pend_reg[e] <= 1'b0;
                end
                if (atm_reg && usb_tx_ack && usb_tx_ep == TXF_EP_W'(e)) begin
                    pend_reg[e] <= 1'b1;
                end
                // drop one set: set 0 before set 1, with no regard to which of the two is older
                if (drop) begin
                    case (s)
                        TXF_SETS_BOTH: s = TXF_SETS_S1;
                        default:       s = TXF_SETS_NONE;
                    endcase
                end
                // add one set at once on a count write
                if (sel && wr_count) begin
                    case (s)
                        TXF_SETS_NONE: s = TXF_SETS_S0;
                        TXF_SETS_S0:   s = TXF_SETS_BOTH;
                        TXF_SETS_S1:   s = TXF_SETS_BOTH;
                        default:       ;
                    endcase
                end
                if (ovf_evt[e]) begin
                    ovf_reg[e] <= 1'b1;
                end
                if (urf_evt[e]) begin
                    urf_reg[e] <= 1'b1;
                end
                // software clears error bits by writing ones, event wins
                if (sel && wr_en && paddr == TXF_OFS_FLAGS) begin
                    if (pwdata[TXF_BIT_OVERFLOW] && !ovf_evt[e]) begin
                        ovf_reg[e] <= 1'b0;
                    end
                    if (pwdata[TXF_BIT_UNDERRUN] && !urf_evt[e]) begin
                        urf_reg[e] <= 1'b0;
                    end
                end
                sets_reg[e] <= s;
            end
        end
    end

    // overflow and underrun events per endpoint
    always_comb begin
        for (int e = 0; e < TXF_NUM_EP; e++) begin
            // a frame drop in the same cycle makes room, so no overflow then
            ovf_evt[e] = wr_count && index_reg == TXF_EP_W'(e)
                         && sets_reg[e] == TXF_SETS_BOTH
                         && !(atm_reg && usb_sof && pend_reg[e]);
            urf_evt[e] = usb_tx_read && usb_tx_ep == TXF_EP_W'(e)
                         && sets_reg[e] == TXF_SETS_NONE;
        end
    end

    // =====================================================================
    // interrupt status, write one to clear, set wins
    logic [TXF_IRQ_W-1:0] irq_evt;
    logic [TXF_IRQ_W-1:0] irq_clr;

    assign irq_evt[TXF_IRQ_OVF] = |ovf_evt;
    assign irq_evt[TXF_IRQ_URF] = |urf_evt;
    assign irq_clr = (wr_en && paddr == TXF_OFS_IRQ_STAT) ? pwdata[TXF_IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
        end
    end

    // level interrupt output
    // built from the next status so it rises one cycle after the event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat_reg & ~irq_clr) | irq_evt) & irq_mask_reg);
        end
    end

endmodule

// >>> verilog/txf_pkg.sv
package txf_pkg;
    // =====================================================================
    // register map (byte addresses on apb)
    localparam logic [7:0]  TXF_OFS_INDEX    = 8'h00;  // endpoint select index
    localparam logic [7:0]  TXF_OFS_FLAGS    = 8'h04;  // transmit fifo flags
    localparam logic [7:0]  TXF_OFS_COUNT    = 8'h08;  // transmit byte count
    localparam logic [7:0]  TXF_OFS_CTL      = 8'h0c;  // transmit control
    localparam logic [7:0]  TXF_OFS_IRQ_STAT = 8'h10;  // interrupt status
    localparam logic [7:0]  TXF_OFS_IRQ_MASK = 8'h14;  // interrupt mask
    // =====================================================================
    // sizes
    localparam int          TXF_NUM_EP       = 16;
    localparam int          TXF_EP_W         = 4;
    localparam int          TXF_CNT_W        = 10;
    // =====================================================================
    // flag register layout
    localparam int          TXF_BIT_SET1     = 7;
    localparam int          TXF_BIT_SET0     = 6;
    localparam int          TXF_BIT_EMPTY    = 3;
    localparam int          TXF_BIT_FULL     = 2;
    localparam int          TXF_BIT_UNDERRUN = 1;
    localparam int          TXF_BIT_OVERFLOW = 0;
    localparam logic [7:0]  TXF_FLAGS_RESET  = 8'h08;
    // =====================================================================
    // control register layout
    localparam int          TXF_BIT_ATM      = 2;
    localparam int          TXF_BIT_ADVANCE  = 1;
    localparam logic [7:0]  TXF_CTL_RESET    = 8'h04;  // auto management on
    // =====================================================================
    // interrupt bits
    localparam int          TXF_IRQ_W        = 2;
    localparam int          TXF_IRQ_OVF      = 0;
    localparam int          TXF_IRQ_URF      = 1;
    // =====================================================================
    // set presence encodings
    localparam logic [1:0]  TXF_SETS_NONE    = 2'b00;
    localparam logic [1:0]  TXF_SETS_S0      = 2'b01;
    localparam logic [1:0]  TXF_SETS_S1      = 2'b10;
    localparam logic [1:0]  TXF_SETS_BOTH    = 2'b11;
endpackage
